// file: rtl/pls_pkg.sv
// shared constants and carrier types for the link and slot status register bank
package pls_pkg;

    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [11:0] PLS_LINK_OFS = 12'h0f0;
    localparam logic [11:0] PLS_SLOT_OFS = 12'h0f4;
    localparam logic [11:0] PLS_INT_STAT_OFS = 12'h100;
    localparam logic [11:0] PLS_INT_MASK_OFS = 12'h104;

    // ----------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------
    localparam logic [3:0] PLS_SPEED_2G5 = 4'h1;
    localparam logic [5:0] PLS_WIDTH_RST = 6'h01;
    localparam logic [7:0] PLS_PWR_VAL_RST = 8'h00;
    localparam logic [1:0] PLS_PWR_SCALE_RST = 2'h0;
    localparam logic [12:0] PLS_SLOT_NUM_RST = 13'h0000;
    localparam int PLS_PWR_LSB = 7;
    localparam int PLS_PWR_MSB = 16;

    // interrupt status bits
    localparam int PLS_IRQ_W = 4;
    localparam int PLS_IRQ_TRN_ERR = 0;
    localparam int PLS_IRQ_TRN_DONE = 1;
    localparam int PLS_IRQ_DL_CHG = 2;
    localparam int PLS_IRQ_SPL_SENT = 3;
    localparam logic [PLS_IRQ_W-1:0] PLS_IRQ_RST = 4'h0;

    // ----------------------------------------------------------------
    // carrier types
    // ----------------------------------------------------------------
    // training state from the physical / data link layers
    typedef struct packed {
        logic training;
        logic train_err;
        logic l0_ok;
        logic [5:0] width;
        logic dl_active;
    } pls_link_s;

    // defaults loaded from the serial management port or eeprom
    typedef struct packed {
        logic slot_clk;
        logic att_btn;
        logic pwr_ctl;
        logic att_ind;
        logic pwr_ind;
        logic surprise;
        logic hot_cap;
        logic [7:0] pwr_val;
        logic [1:0] pwr_scale;
        logic [12:0] slot_num;
    } pls_load_s;

    // set_slot_power_limit message request
    typedef struct packed {
        logic [7:0] pwr_val;
        logic [1:0] pwr_scale;
    } pls_spl_s;

endpackage : pls_pkg

// file: rtl/pls_regs.sv
// link status and slot capabilities register bank with apb slave and interrupt
//
// Summary of operation
// - link speed bits 19:16 always read 0001b for the 2.5 Gb/s rate.
// - bits 25:20 report the negotiated lane count and reset to a single lane.
// - bit 26 is set on a training error, cleared on reaching L0, and resets to zero.
// - bit 27 is high while training runs, cleared when it finishes, and resets to zero.
// - bit 28 shows the slot clock source and its default comes from a strap or a load.
// - bit 29 reads one only while the data link machine is in DL_Active.
// - slot bits 0, 1 and 3 are read-only presence flags that reset to zero.
// - slot bit 4 is a read-only power indicator flag that resets to zero.
// - slot bit 5 is a read-only surprise removal flag that resets to zero.
// - slot bit 6 reports hot-plug support with its default from a strap or a load.
// - bits 14:7 hold a writable power limit, reset 00h, and a write sends a power limit message.
// - bits 16:15 hold a writable power scale, reset 00b, and a write sends a power limit message.
// - bits 31:19 hold a read-only physical slot number that resets to zero.
// - slot defaults can be replaced through the management load port.
module pls_regs
    import pls_pkg::*;
(
    // apb clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // straps, sampled once after reset release
    input wire logic strap_slot_clk,
    input wire logic strap_hot_cap,
    // management or eeprom default load
    input wire logic load_valid,
    input wire pls_pkg::pls_load_s load_data,
    // link training state
    input wire pls_pkg::pls_link_s link_in,
    // set_slot_power_limit message
    output logic spl_msg_valid,
    input wire logic spl_msg_ready,
    output pls_pkg::pls_spl_s spl_msg,
    // interrupt
    output logic irq
);
    import pls_pkg::*;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] strb_mask(input logic [3:0] strb);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int i = 0; i < 4; i++)
        begin
            m[i*8 +: 8] = {8{strb[i]}};
        end
        return m;
    endfunction : strb_mask

    function automatic logic addr_is(input logic [11:0] a, input logic [11:0] ofs);
        return a[11:2] == ofs[11:2];
    endfunction : addr_is

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic setup_ph;
    logic access_ph;
    logic wr_acc;
    logic rd_acc;
    logic [31:0] wmask;
    logic slot_wr;
    logic spl_fire;
    logic spl_done;
    logic stat_rd;
    logic mapped;

    logic strap_done_reg;
    logic train_err_reg;
    logic training_reg;
    logic [5:0] width_reg;
    logic dl_active_reg;
    logic slot_clk_reg;
    logic att_btn_reg;
    logic pwr_ctl_reg;
    logic att_ind_reg;
    logic pwr_ind_reg;
    logic surprise_reg;
    logic hot_cap_reg;
    logic [7:0] pwr_val_reg;
    logic [1:0] pwr_scale_reg;
    logic [12:0] slot_num_reg;
    logic spl_pend_reg;
    logic [PLS_IRQ_W-1:0] int_stat_reg;
    logic [PLS_IRQ_W-1:0] int_mask_reg;
    logic [PLS_IRQ_W-1:0] int_set;
    logic [31:0] link_word;
    logic [31:0] slot_word;
    logic [31:0] rd_next;
    logic [9:0] pwr_next;

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    // zero wait states: read data is fetched in the setup cycle
    assign setup_ph = psel && !penable;
    assign access_ph = psel && penable;
    assign wr_acc = access_ph && pwrite && !pslverr;
    assign rd_acc = access_ph && !pwrite;
    assign pready = access_ph;
    assign wmask = strb_mask(pstrb);
    assign mapped = addr_is(paddr, PLS_LINK_OFS) || addr_is(paddr, PLS_SLOT_OFS)
        || addr_is(paddr, PLS_INT_STAT_OFS) || addr_is(paddr, PLS_INT_MASK_OFS);

    // only the power bytes are writable; a write touching them sends the message
    assign slot_wr = wr_acc && addr_is(paddr, PLS_SLOT_OFS)
        && (|wmask[PLS_PWR_MSB:PLS_PWR_LSB]);
    assign pwr_next = ({pwr_scale_reg, pwr_val_reg} & ~wmask[PLS_PWR_MSB:PLS_PWR_LSB])
        | (pwdata[PLS_PWR_MSB:PLS_PWR_LSB] & wmask[PLS_PWR_MSB:PLS_PWR_LSB]);
    assign stat_rd = rd_acc && !pslverr && addr_is(paddr, PLS_INT_STAT_OFS);

    // ----------------------------------------------------------------
    // read data words
    // ----------------------------------------------------------------
    // link control half (15:0) lives elsewhere and reads as zero here
    assign link_word = {2'b00,
                        dl_active_reg,
                        slot_clk_reg,
                        training_reg,
                        train_err_reg,
                        width_reg,
                        PLS_SPEED_2G5,
                        16'h0000};

    assign slot_word = {slot_num_reg,
                        2'b00,
                        pwr_scale_reg,
                        pwr_val_reg,
                        hot_cap_reg,
                        surprise_reg,
                        pwr_ind_reg,
                        att_ind_reg,
                        1'b0,
                        pwr_ctl_reg, att_btn_reg};

    assign rd_next = addr_is(paddr, PLS_LINK_OFS) ? link_word
        : addr_is(paddr, PLS_SLOT_OFS) ? slot_word
        : addr_is(paddr, PLS_INT_STAT_OFS) ? {28'h000_0000, int_stat_reg}
        : addr_is(paddr, PLS_INT_MASK_OFS) ? {28'h000_0000, int_mask_reg} : 32'h0000_0000;

    // ----------------------------------------------------------------
    // bus answer registers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (setup_ph)
        begin
            prdata <= pwrite ? 32'h0000_0000 : rd_next;
            pslverr <= !mapped;
        end
    end

    // ----------------------------------------------------------------
    // link training status
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            train_err_reg <= 1'b0;
        end
        else if (link_in.train_err)
        begin
            train_err_reg <= 1'b1;
        end
        else if (link_in.l0_ok)
        begin
            train_err_reg <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            training_reg <= 1'b0;
            dl_active_reg <= 1'b0;
        end
        else
        begin
            training_reg <= link_in.training;
            dl_active_reg <= link_in.dl_active;
        end
    end

    // width is latched when training completes into L0
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            width_reg <= PLS_WIDTH_RST;
        end
        else if (link_in.l0_ok)
        begin
            width_reg <= link_in.width;
        end
    end

    // ----------------------------------------------------------------
    // strap capture and default loading
    // ----------------------------------------------------------------
    // straps are caught at the first edge after release, not by the reset itself
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            strap_done_reg <= 1'b0;
        end
        else
        begin
            strap_done_reg <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            slot_clk_reg <= 1'b0;
            hot_cap_reg <= 1'b0;
        end
        else if (load_valid)
        begin
            slot_clk_reg <= load_data.slot_clk;
            hot_cap_reg <= load_data.hot_cap;
        end
        else if (!strap_done_reg)
        begin
            slot_clk_reg <= strap_slot_clk;
            hot_cap_reg <= strap_hot_cap;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            att_btn_reg <= 1'b0;
            pwr_ctl_reg <= 1'b0;
            att_ind_reg <= 1'b0;
            pwr_ind_reg <= 1'b0;
            surprise_reg <= 1'b0;
            slot_num_reg <= PLS_SLOT_NUM_RST;
        end
        else if (load_valid)
        begin
            att_btn_reg <= load_data.att_btn;
            pwr_ctl_reg <= load_data.pwr_ctl;
            att_ind_reg <= load_data.att_ind;
            pwr_ind_reg <= load_data.pwr_ind;
            surprise_reg <= load_data.surprise;
            slot_num_reg <= load_data.slot_num;
        end
    end

    // ----------------------------------------------------------------
    // slot power limit fields
    // ----------------------------------------------------------------
    // a software write in the same cycle as a load wins, since it also sends a message
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pwr_val_reg <= PLS_PWR_VAL_RST;
            pwr_scale_reg <= PLS_PWR_SCALE_RST;
        end
        else if (slot_wr)
        begin
            pwr_val_reg <= pwr_next[7:0];
            pwr_scale_reg <= pwr_next[9:8];
        end
        else if (load_valid)
        begin
            pwr_val_reg <= load_data.pwr_val;
            pwr_scale_reg <= load_data.pwr_scale;
        end
    end

    // ----------------------------------------------------------------
    // set_slot_power_limit message request
    // ----------------------------------------------------------------
    // back-to-back writes merge into one pending message carrying the latest value
    assign spl_fire = slot_wr;
    assign spl_done = spl_pend_reg && spl_msg_ready;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            spl_pend_reg <= 1'b0;
        end
        else if (spl_fire)
        begin
            spl_pend_reg <= 1'b1;
        end
        else if (spl_done)
        begin
            spl_pend_reg <= 1'b0;
        end
    end

    assign spl_msg_valid = spl_pend_reg;
    assign spl_msg.pwr_val = pwr_val_reg;
    assign spl_msg.pwr_scale = pwr_scale_reg;

    // ----------------------------------------------------------------
    // interrupt status and mask
    // ----------------------------------------------------------------
    always_comb
    begin
        int_set = PLS_IRQ_RST;
        int_set[PLS_IRQ_TRN_ERR] = link_in.train_err;
        int_set[PLS_IRQ_TRN_DONE] = training_reg && !link_in.training;
        int_set[PLS_IRQ_DL_CHG] = dl_active_reg != link_in.dl_active;
        int_set[PLS_IRQ_SPL_SENT] = spl_done;
    end

    // a read clears only the bits it returned, so an event landing at the setup edge is not lost
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            int_stat_reg <= PLS_IRQ_RST;
        end
        else if (stat_rd)
        begin
            int_stat_reg <= (int_stat_reg & ~prdata[PLS_IRQ_W-1:0]) | int_set;
        end
        else
        begin
            int_stat_reg <= int_stat_reg | int_set;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            int_mask_reg <= PLS_IRQ_RST;
        end
        else if (wr_acc && addr_is(paddr, PLS_INT_MASK_OFS) && pstrb[0])
        begin
            int_mask_reg <= pwdata[PLS_IRQ_W-1:0];
        end
    end

    assign irq = |(int_stat_reg & int_mask_reg);

endmodule : pls_regs

// file: sim/pls_link_peer.sv
// behavioural link-side consumer of slot power limit messages
module pls_link_peer
    import pls_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // message handshake
    input wire logic spl_msg_valid,
    output logic spl_msg_ready,
    input wire pls_pkg::pls_spl_s spl_msg,
    // bench view
    input wire logic slow,
    output int n_msgs,
    output pls_pkg::pls_spl_s last_msg
);
    int wait_cnt;

    // a slow peer holds ready off so later writes land while one is pending
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            spl_msg_ready <= 1'b0;
            wait_cnt <= 0;
            n_msgs <= 0;
            last_msg <= '0;
        end
        else if (spl_msg_valid && spl_msg_ready)
        begin
            spl_msg_ready <= 1'b0;
            wait_cnt <= 0;
            n_msgs <= n_msgs + 1;
            last_msg <= spl_msg;
        end
        else if (spl_msg_valid)
        begin
            wait_cnt <= wait_cnt + 1;
            spl_msg_ready <= !slow || wait_cnt >= 3;
        end
        else
        begin
            wait_cnt <= 0;
            spl_msg_ready <= 1'b0;
        end
    end
endmodule : pls_link_peer

// file: sim/pls_regs_sva.sv
// concurrent checks on the ports of the link and slot status register bank
module pls_regs_sva
    import pls_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    // link state and message
    input wire pls_pkg::pls_link_s link_in,
    input wire logic spl_msg_valid,
    input wire logic spl_msg_ready,
    input wire pls_pkg::pls_spl_s spl_msg
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // ----------------------------------------------------------------
    // access phases
    // ----------------------------------------------------------------
    sequence s_rd_link;
        psel && penable && !pwrite && paddr[11:2] == PLS_LINK_OFS[11:2];
    endsequence
    sequence s_rd_slot;
        psel && penable && !pwrite && paddr[11:2] == PLS_SLOT_OFS[11:2];
    endsequence
    sequence s_wr_slot;
        psel && penable && pwrite && paddr[11:2] == PLS_SLOT_OFS[11:2];
    endsequence

    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    property p_speed;
        s_rd_link |-> prdata[19:16] == PLS_SPEED_2G5;
    endproperty
    a_speed: assert property (p_speed) else $error("link speed field wrong");
    property p_link_rsvd;
        s_rd_link |-> prdata[31:30] == 2'h0 && prdata[15:0] == 16'h0000;
    endproperty
    a_link_rsvd: assert property (p_link_rsvd) else $error("link reserved bits set");
    property p_slot_rsvd;
        s_rd_slot |-> prdata[18:17] == 2'h0 && prdata[2] == 1'b0;
    endproperty
    a_slot_rsvd: assert property (p_slot_rsvd) else $error("slot reserved bits set");
    property p_spl_req;
        s_wr_slot ##0 pstrb[2:0] != 3'h0 |=> spl_msg_valid;
    endproperty
    a_spl_req: assert property (p_spl_req) else $error("power write sent no message");
    property p_spl_hold;
        spl_msg_valid && !spl_msg_ready |=> spl_msg_valid;
    endproperty
    a_spl_hold: assert property (p_spl_hold) else $error("message dropped unaccepted");
    property p_spl_val;
        s_wr_slot ##0 pstrb[1:0] == 2'h3 |=> spl_msg.pwr_val == $past(pwdata[14:7]);
    endproperty
    a_spl_val: assert property (p_spl_val) else $error("message value wrong");
    property p_spl_scale;
        s_wr_slot ##0 pstrb[2:1] == 2'h3 |=> spl_msg.pwr_scale == $past(pwdata[16:15]);
    endproperty
    a_spl_scale: assert property (p_spl_scale) else $error("message scale wrong");
    // inputs held steady three edges so either load point of read data agrees
    property p_dl_mirror;
        s_rd_link ##0 ($past(link_in.dl_active) == $past(link_in.dl_active, 2)
            && $past(link_in.dl_active, 2) == $past(link_in.dl_active, 3))
            |-> prdata[29] == $past(link_in.dl_active, 2);
    endproperty
    a_dl_mirror: assert property (p_dl_mirror) else $error("link active bit wrong");
    property p_trn_mirror;
        s_rd_link ##0 ($past(link_in.training) == $past(link_in.training, 2)
            && $past(link_in.training, 2) == $past(link_in.training, 3))
            |-> prdata[27] == $past(link_in.training, 2);
    endproperty
    a_trn_mirror: assert property (p_trn_mirror) else $error("training bit wrong");
endmodule : pls_regs_sva

bind pls_regs pls_regs_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .link_in(link_in),
    .spl_msg_valid(spl_msg_valid), .spl_msg_ready(spl_msg_ready), .spl_msg(spl_msg));

// file: sim/pls_regs_tb.sv
// self-checking bench for the link and slot status register bank
module pls_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pls_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic strap_slot_clk, strap_hot_cap, load_valid, spl_msg_valid, spl_msg_ready, slow;
    pls_load_s load_data;
    pls_link_s link_in;
    pls_spl_s spl_msg, last_msg;
    int n_msgs, n_mismatch, n_checks;

    pls_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .strap_slot_clk(strap_slot_clk), .strap_hot_cap(strap_hot_cap), .load_valid(load_valid),
        .load_data(load_data), .link_in(link_in), .spl_msg_valid(spl_msg_valid),
        .spl_msg_ready(spl_msg_ready), .spl_msg(spl_msg), .irq(irq));
    pls_link_peer peer (.pclk(pclk), .presetn(presetn), .spl_msg_valid(spl_msg_valid),
        .spl_msg_ready(spl_msg_ready), .spl_msg(spl_msg), .slow(slow), .n_msgs(n_msgs), .last_msg(last_msg));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // the access phase lasts until the slave answers; only the watchdog ends a hung wait
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rdchk

    task automatic wait_msgs(input int target);
        int n;
        n = 0;
        while (n_msgs < target && n < 64)
        begin
            @(posedge pclk);
            n++;
        end
        chk(n_msgs, target);
    endtask : wait_msgs

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // the whole sequence needs under a hundred cycles
    initial
    begin
        #(4000 * 5);
        n_mismatch++;
        tally_and_finish();
    end

    initial
    begin
        presetn = 1'b0;
        {psel, penable, pwrite, load_valid, slow} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hf;
        strap_slot_clk = 1'b1;
        strap_hot_cap = 1'b1;
        load_data = '0;
        link_in = '0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        rdchk(PLS_LINK_OFS, 32'h1011_0000);
        rdchk(PLS_SLOT_OFS, 32'h0000_0040);
        $display("test reset values done");
        xfer(1'b1, PLS_SLOT_OFS, 32'hffff_ffff);
        rdchk(PLS_SLOT_OFS, 32'h0001_ffc0);
        wait_msgs(1);
        chk({22'h0, last_msg}, 32'h0000_03ff);
        xfer(1'b1, PLS_LINK_OFS, 32'hffff_ffff);
        rdchk(PLS_LINK_OFS, 32'h1011_0000);
        $display("test write all ones done");
        slow <= 1'b1;
        xfer(1'b1, PLS_SLOT_OFS, 32'h0000_5a80);
        xfer(1'b1, PLS_SLOT_OFS, 32'h0001_2400);
        wait_msgs(2);
        chk({22'h0, last_msg}, 32'h0000_0122);
        rdchk(PLS_SLOT_OFS, 32'h0001_2440);
        chk(n_msgs, 2);
        slow <= 1'b0;
        $display("test pending message done");
        load_data <= {1'b0, 5'h1f, 1'b0, 8'h12, 2'h1, 13'h1abc};
        load_valid <= 1'b1;
        @(posedge pclk);
        load_valid <= 1'b0;
        rdchk(PLS_SLOT_OFS, 32'hd5e0_893b);
        rdchk(PLS_LINK_OFS, 32'h0011_0000);
        chk(n_msgs, 2);
        pstrb <= 4'h2;
        xfer(1'b1, PLS_SLOT_OFS, 32'h0000_0000);
        pstrb <= 4'hf;
        rdchk(PLS_SLOT_OFS, 32'hd5e0_003b);
        wait_msgs(3);
        $display("test default load done");
        link_in.training <= 1'b1;
        repeat (3) @(posedge pclk);
        rdchk(PLS_LINK_OFS, 32'h0811_0000);
        link_in.train_err <= 1'b1;
        @(posedge pclk);
        link_in.train_err <= 1'b0;
        repeat (2) @(posedge pclk);
        rdchk(PLS_LINK_OFS, 32'h0c11_0000);
        link_in.training <= 1'b0;
        link_in.l0_ok <= 1'b1;
        link_in.width <= 6'h04;
        link_in.dl_active <= 1'b1;
        @(posedge pclk);
        link_in.l0_ok <= 1'b0;
        repeat (3) @(posedge pclk);
        rdchk(PLS_LINK_OFS, 32'h2041_0000);
        link_in.dl_active <= 1'b0;
        repeat (3) @(posedge pclk);
        rdchk(PLS_LINK_OFS, 32'h0041_0000);
        $display("test link training done");
        @(negedge pclk);
        chk({31'h0, irq}, 32'h0);
        xfer(1'b1, PLS_INT_MASK_OFS, 32'h0000_000f);
        @(negedge pclk);
        chk({31'h0, irq}, 32'h1);
        rdchk(PLS_INT_STAT_OFS, 32'h0000_000f);
        @(negedge pclk);
        chk({31'h0, irq}, 32'h0);
        rdchk(PLS_INT_STAT_OFS, 32'h0000_0000);
        rdchk(PLS_INT_MASK_OFS, 32'h0000_000f);
        rdchk(12'h108, 32'h0);
        chk({31'h0, err}, 32'h1);
        $display("test interrupt and unmapped done");
        tally_and_finish();
    end
endmodule : pls_regs_tb
